/* hw/pccm_monitor.v */
// press contact cycle monitor with apb register access
// Operation
// - leaving the upper contact when the press should stand raises ramp-down error
// - drive command must rise in top, or be high when top falls
// - advance contact falling edge starts the top phase early
// - upstroke rises on lower rise, falls on upper rise or advance fall
// - advance fall in downward phase holds top to lower rise, no upstroke
// - enable low drops release and suspends checks, errors untouched
// - enable rising re-enters the state given by the contacts
// - release high while enabled and free of errors
// - sequence fault drops release, raises error and restart-needed
// - top rises on upper rise or advance fall, falls on upper fall
// - any error forces upstroke and top low
// - restart-needed holds until valid restart; release never high with it
// - any contact order departure raises contact error; advance changes order
// - optional summary error flag follows either error
// - both errors latch until a valid restart pulse
// - restart accepted only as pulse of min to 30 s high time
// - without restart input only a run stop and start clears errors
`timescale 1ns/1ns
`include "pccm_defs.vh"
module pccm_monitor #(
	parameter TICK_CYC = (`PCCM_TICK_US * `PCCM_CLK_MHZ)
) (
	// clock and reset
	input  wire        mclk,
	input  wire        rst_n,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output reg         pslverr,
	// contact and control pins
	input  wire        upper_position_contact,
	input  wire        lower_position_contact,
	input  wire        advance_contact,
	input  wire        enable_in,
	input  wire        restart_in,
	// drive command from downstream logic
	input  wire        drive_cmd,
	// monitor outputs
	output reg         release_out,
	output reg         top_out,
	output reg         upstroke_out,
	output reg         restart_needed,
	output reg         contact_error,
	output reg         rampdown_error,
	output reg         error_flag,
	output wire        irq
);
	// pulse limits worked out in 32 bits, then cut to the counter width on purpose
	localparam integer MIN_A_I =
		(`PCCM_RST_MIN_A_MS * 1000 + `PCCM_TICK_US - 1) / `PCCM_TICK_US;
	localparam integer MIN_B_I =
		(`PCCM_RST_MIN_B_MS * 1000 + `PCCM_TICK_US - 1) / `PCCM_TICK_US;
	localparam integer MAX_T_I =
		(`PCCM_RST_MAX_MS * 1000) / `PCCM_TICK_US;
	localparam [`PCCM_CNT_W-1:0] MIN_A = MIN_A_I[`PCCM_CNT_W-1:0];
	localparam [`PCCM_CNT_W-1:0] MIN_B = MIN_B_I[`PCCM_CNT_W-1:0];
	localparam [`PCCM_CNT_W-1:0] MAX_T = MAX_T_I[`PCCM_CNT_W-1:0];
	localparam [`PCCM_CNT_W-1:0] CNT_TOP = {`PCCM_CNT_W{1'b1}};
	// one-hot states
	localparam [2:0] ST_OFF = 3'h1;
	localparam [2:0] ST_RUN = 3'h2;
	localparam [2:0] ST_ERR = 3'h4;

	function is_rise;
		input cur;
		input prv;
		is_rise = cur & ~prv;
	endfunction

	// input synchronisers: a change counts when stages two and three agree
	wire [4:0] pin_raw = {restart_in, enable_in, advance_contact,
		lower_position_contact, upper_position_contact};
	reg  [4:0] sy1_q;
	reg  [4:0] sy2_q;
	reg  [4:0] sy3_q;
	reg  [4:0] flt_q;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sy1_q <= 5'h00;
			sy2_q <= 5'h00;
			sy3_q <= 5'h00;
			flt_q <= 5'h00;
		end else begin
			sy1_q <= pin_raw;
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
			flt_q <= (sy2_q & sy3_q) | (flt_q & (sy2_q ^ sy3_q)) |
				(flt_q & sy2_q & sy3_q);
		end
	end
	wire up_c  = flt_q[0];
	wire lo_c  = flt_q[1];
	wire adv_c = flt_q[2];
	wire en_c  = flt_q[3];
	wire rs_c  = flt_q[4];

	// logic execution cycle: one-cycle enable from a divider
	reg  [31:0] div_q;
	reg         tick_q;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_q  <= 32'h00000000;
			tick_q <= 1'b0;
		end else if (div_q >= TICK_CYC - 1) begin
			div_q  <= 32'h00000000;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + 32'h00000001;
			tick_q <= 1'b0;
		end
	end

	// registers
	reg  [4:0]           ctrl_q;
	reg  [`PCCM_IRQ_W-1:0] ist_q;
	reg  [`PCCM_IRQ_W-1:0] ien_q;
	wire run    = ctrl_q[`PCCM_CTRL_RUN];
	wire rst_en = ctrl_q[`PCCM_CTRL_RSTEN];
	wire adv_en = ctrl_q[`PCCM_CTRL_ADVEN];

	// previous-cycle samples and cycle state
	reg  [2:0]           st_q;
	reg                  up_p_q;
	reg                  lo_p_q;
	reg                  adv_p_q;
	reg                  en_p_q;
	reg                  rs_p_q;
	reg                  drv_p_q;
	reg                  hold_q;
	reg                  noup_q;
	reg                  seen_q;
	reg  [`PCCM_CNT_W-1:0] hi_cnt_q;

	// edges relative to the previous logic cycle
	wire adv_use = adv_c | ~adv_en;
	wire up_r  = is_rise(up_c, up_p_q);
	wire up_f  = is_rise(up_p_q, up_c);
	wire lo_r  = is_rise(lo_c, lo_p_q);
	wire lo_f  = is_rise(lo_p_q, lo_c);
	wire adv_f = adv_en & is_rise(adv_p_q, adv_c);
	wire drv_r = is_rise(drive_cmd, drv_p_q);
	wire en_r  = is_rise(en_c, en_p_q);
	wire rs_f  = is_rise(rs_p_q, rs_c);

	// order check; the advance contact must fall before the upper contact rises
	wire seq_bad = (up_r & ~lo_c) | (up_f & lo_c) | (lo_r & up_c) |
		(lo_f & ~up_c) | (adv_en & adv_f & up_c);
	wire [`PCCM_CNT_W-1:0] min_t = ctrl_q[`PCCM_CTRL_MIN350] ? MIN_B : MIN_A;
	wire rs_ok = rst_en & rs_f & (hi_cnt_q >= min_t) & (hi_cnt_q <= MAX_T);

	// next-state of the top phase
	reg  top_d;
	reg  up_d;
	reg  hold_d;
	reg  noup_d;
	always @* begin
		top_d  = top_out;
		up_d   = upstroke_out;
		hold_d = hold_q;
		noup_d = noup_q;
		if (up_r | adv_f)
			top_d = 1'b1;
		if (up_f & ~hold_q)
			top_d = 1'b0;
		if (adv_f & ~lo_c) begin
			top_d  = 1'b1;
			hold_d = 1'b1;
			noup_d = 1'b1;
		end
		if (lo_r & hold_q) begin
			top_d  = up_c;
			hold_d = 1'b0;
		end
		if (lo_r & ~noup_d)
			up_d = 1'b1;
		if (up_r | adv_f)
			up_d = 1'b0;
		if (up_f & ~adv_f)
			noup_d = hold_d;
	end
	wire top_fall = top_out & ~top_d;
	wire ramp_bad = top_fall & ~(seen_q | drv_r | drive_cmd);

	reg  ev_cerr;
	reg  ev_rerr;
	reg  ev_rst;
	reg  ev_top;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q           <= ST_OFF;
			up_p_q         <= 1'b0;
			lo_p_q         <= 1'b0;
			adv_p_q        <= 1'b0;
			en_p_q         <= 1'b0;
			rs_p_q         <= 1'b0;
			drv_p_q        <= 1'b0;
			hold_q         <= 1'b0;
			noup_q         <= 1'b0;
			seen_q         <= 1'b0;
			hi_cnt_q       <= {`PCCM_CNT_W{1'b0}};
			release_out    <= 1'b0;
			top_out        <= 1'b0;
			upstroke_out   <= 1'b0;
			restart_needed <= 1'b0;
			contact_error  <= 1'b0;
			rampdown_error <= 1'b0;
			error_flag     <= 1'b0;
			ev_cerr        <= 1'b0;
			ev_rerr        <= 1'b0;
			ev_rst         <= 1'b0;
			ev_top         <= 1'b0;
		end else begin
			ev_cerr <= 1'b0;
			ev_rerr <= 1'b0;
			ev_rst  <= 1'b0;
			ev_top  <= 1'b0;
			if (!run) begin
				// stopped program: errors and state cleared, as at power-up
				st_q           <= ST_OFF;
				release_out    <= 1'b0;
				top_out        <= 1'b0;
				upstroke_out   <= 1'b0;
				restart_needed <= 1'b0;
				contact_error  <= 1'b0;
				rampdown_error <= 1'b0;
				error_flag     <= 1'b0;
				en_p_q         <= 1'b0;
			end else if (tick_q) begin
				up_p_q  <= up_c;
				lo_p_q  <= lo_c;
				adv_p_q <= adv_use;
				en_p_q  <= en_c;
				rs_p_q  <= rs_c;
				drv_p_q <= drive_cmd;
				if (rs_c)
					hi_cnt_q <= (hi_cnt_q == CNT_TOP) ? hi_cnt_q :
						hi_cnt_q + 1'b1;
				else
					hi_cnt_q <= {`PCCM_CNT_W{1'b0}};
				case (st_q)
				ST_OFF: begin
					release_out <= 1'b0;
					if (en_r) begin
						// pick up the phase the contacts show now
						st_q         <= ST_RUN;
						release_out  <= 1'b1;
						top_out      <= up_c;
						upstroke_out <= lo_c & ~up_c;
						hold_q       <= 1'b0;
						noup_q       <= 1'b0;
						seen_q       <= 1'b0;
					end
				end
				ST_RUN: begin
					if (!en_c) begin
						st_q        <= ST_OFF;
						release_out <= 1'b0;
					end else if (seq_bad | ramp_bad) begin
						st_q           <= ST_ERR;
						release_out    <= 1'b0;
						restart_needed <= 1'b1;
						contact_error  <= contact_error | seq_bad;
						rampdown_error <= rampdown_error | ramp_bad;
						top_out        <= 1'b0;
						upstroke_out   <= 1'b0;
						ev_cerr        <= seq_bad;
						ev_rerr        <= ramp_bad;
					end else begin
						release_out  <= 1'b1;
						top_out      <= top_d;
						upstroke_out <= up_d;
						hold_q       <= hold_d;
						noup_q       <= noup_d;
						ev_top       <= ~top_out & top_d;
						if (top_d & drv_r)
							seen_q <= 1'b1;
						else if (~top_d)
							seen_q <= 1'b0;
					end
				end
				ST_ERR: begin
					release_out  <= 1'b0;
					top_out      <= 1'b0;
					upstroke_out <= 1'b0;
					if (rs_ok) begin
						// errors latch until a good pulse; then re-enter from contacts
						st_q           <= en_c ? ST_RUN : ST_OFF;
						restart_needed <= 1'b0;
						contact_error  <= 1'b0;
						rampdown_error <= 1'b0;
						release_out    <= en_c;
						top_out        <= en_c & up_c;
						upstroke_out   <= en_c & lo_c & ~up_c;
						hold_q         <= 1'b0;
						noup_q         <= 1'b0;
						seen_q         <= 1'b0;
						ev_rst         <= 1'b1;
					end
				end
				default: st_q <= ST_OFF;
				endcase
			end
			error_flag <= ctrl_q[`PCCM_CTRL_FLAGEN] &
				(contact_error | rampdown_error);
		end
	end

	// apb slave, zero wait states; read data latched in the setup phase
	wire setup   = psel & ~penable;
	wire wr_acc  = psel & penable & pwrite;
	wire hit_reg = (paddr == `PCCM_OFS_CTRL) | (paddr == `PCCM_OFS_STATUS) |
		(paddr == `PCCM_OFS_IRQ_ST) | (paddr == `PCCM_OFS_IRQ_CLR) |
		(paddr == `PCCM_OFS_IRQ_EN);
	assign pready = 1'b1;
	wire [`PCCM_IRQ_W-1:0] ev_vec = {ev_top, ev_rst, ev_rerr, ev_cerr};
	wire [`PCCM_IRQ_W-1:0] clr_vec = (wr_acc && paddr == `PCCM_OFS_IRQ_CLR) ?
		pwdata[`PCCM_IRQ_W-1:0] : {`PCCM_IRQ_W{1'b0}};
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q  <= `PCCM_CTRL_RESET;
			ist_q   <= {`PCCM_IRQ_W{1'b0}};
			ien_q   <= {`PCCM_IRQ_W{1'b0}};
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			// a new event wins over a clear in the same cycle
			ist_q <= (ist_q & ~clr_vec) | ev_vec;
			if (wr_acc && paddr == `PCCM_OFS_CTRL)
				ctrl_q <= pwdata[4:0];
			if (wr_acc && paddr == `PCCM_OFS_IRQ_EN)
				ien_q <= pwdata[`PCCM_IRQ_W-1:0];
			if (setup) begin
				pslverr <= ~hit_reg;
				case (paddr)
				`PCCM_OFS_CTRL:   prdata <= {27'h0000000, ctrl_q};
				`PCCM_OFS_STATUS: prdata <= {17'h00000, en_c, rs_c, adv_c, lo_c, up_c,
					st_q, error_flag, rampdown_error, contact_error, restart_needed,
					upstroke_out, top_out, release_out};
				`PCCM_OFS_IRQ_ST: prdata <= {28'h0000000, ist_q};
				`PCCM_OFS_IRQ_EN: prdata <= {28'h0000000, ien_q};
				default:          prdata <= 32'h00000000;
				endcase
			end
		end
	end
	assign irq = |(ist_q & ien_q);
endmodule // pccm_monitor

/* pkg/pccm_defs.vh */
// constants for the press contact cycle monitor
`ifndef PCCM_DEFS_VH
`define PCCM_DEFS_VH
// register byte offsets
`define PCCM_OFS_CTRL    8'h00
`define PCCM_OFS_STATUS  8'h04
`define PCCM_OFS_IRQ_ST  8'h08
`define PCCM_OFS_IRQ_CLR 8'h0C
`define PCCM_OFS_IRQ_EN  8'h10
// control fields
`define PCCM_CTRL_RUN    0
`define PCCM_CTRL_RSTEN  1
`define PCCM_CTRL_MIN350 2
`define PCCM_CTRL_ADVEN  3
`define PCCM_CTRL_FLAGEN 4
`define PCCM_CTRL_RESET  5'h00
// interrupt fields
`define PCCM_IRQ_CERR    0
`define PCCM_IRQ_RERR    1
`define PCCM_IRQ_RESTART 2
`define PCCM_IRQ_TOP     3
`define PCCM_IRQ_W       4
// timing
`define PCCM_CLK_MHZ     125
`define PCCM_TICK_US     1000
`define PCCM_RST_MIN_A_MS 100
`define PCCM_RST_MIN_B_MS 350
`define PCCM_RST_MAX_MS  30000
`define PCCM_CNT_W       16
`endif

/* tb/pccm_monitor_checker.sv */
// assertion checker for the press contact cycle monitor
`timescale 1ns/1ns
module pccm_monitor_checker (
	// clock
	input wire mclk,
	input wire rst_n,
	// inputs
	input wire psel,
	input wire enable_in,
	input wire restart_in,
	// outputs
	input wire release_out,
	input wire top_out,
	input wire upstroke_out,
	input wire restart_needed,
	input wire contact_error,
	input wire rampdown_error,
	input wire error_flag
);
	wire any_err = contact_error | rampdown_error;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	err_forces_low_a:
		assert property (any_err |-> !top_out && !upstroke_out) else $error("top with error");
	restart_blocks_a:
		assert property (restart_needed |-> !release_out) else $error("release in restart");
	release_clean_a:
		assert property (release_out |-> !any_err) else $error("release with error");
	enable_drop_a:
		assert property ($fell(enable_in) |-> ##[1:12] !release_out) else $error("release stuck");
	flag_follows_a:
		assert property (error_flag |-> $past(any_err)) else $error("flag without error");
	err_hold_a:
		assert property (any_err && restart_in && !psel |=> any_err) else $error("error lost");
	up_top_excl_a:
		assert property (!(top_out && upstroke_out)) else $error("top and upstroke");
	ramp_trip_a:
		assert property ($rose(rampdown_error) |-> restart_needed && !release_out)
			else $error("ramp trip incomplete");
	contact_trip_a:
		assert property ($rose(contact_error) |-> restart_needed && !release_out)
			else $error("contact trip incomplete");
	cover property ($rose(rampdown_error));
	cover property ($rose(contact_error));
	cover property ($fell(restart_needed));
endmodule // pccm_monitor_checker

/* tb/pccm_press_model.sv */
// behavioural press: position contacts and drive command
`timescale 1ns/1ns
module pccm_press_model #(
	parameter [7:0] GAP = 8'h28
) (
	// clock
	input  wire mclk,
	input  wire rst_n,
	// controls
	input  wire go,
	input  wire bad,
	input  wire adv,
	input  wire drive_ok,
	// press side
	output reg  upper_q,
	output reg  lower_q,
	output reg  adv_q,
	output wire drive_cmd
);
	reg [2:0] st_q;
	reg [7:0] cnt_q;
	// the downstream drive command is taken straight from the drive_ok control
	assign drive_cmd = drive_ok;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= 3'h0;
			cnt_q <= 8'h00;
			upper_q <= 1'h1;
			lower_q <= 1'h0;
			adv_q <= 1'h1;
		end else if (st_q == 3'h0) begin
			st_q <= go ? 3'h1 : 3'h0;
		end else if (cnt_q != GAP) begin
			cnt_q <= cnt_q + 8'h01;
		end else begin
			// one change per step; bad skips the lower rise
			cnt_q <= 8'h00;
			st_q <= (st_q == 3'h6) ? 3'h0 : st_q + 3'h1;
			case (st_q)
				3'h1: upper_q <= 1'h0;
				3'h2: lower_q <= !bad;
				3'h3: adv_q <= !adv;
				3'h4: upper_q <= 1'h1;
				3'h5: lower_q <= 1'h0;
				default: adv_q <= 1'h1;
			endcase
		end
	end
endmodule // pccm_press_model

/* tb/testbench.sv */
// self-checking bench for the press contact cycle monitor
`timescale 1ns/1ns
`include "pccm_defs.vh"
module testbench;
	localparam int ST = 41;
	reg        mclk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	reg        enable_in = 1'h0, restart_in = 1'h0, go = 1'h0, bad = 1'h0, adv = 1'h0;
	reg        drive_ok = 1'h1;
	reg  [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire        pready, pslverr, upper, lower, advance, drive_cmd, irq, release_out, top_out;
	wire        upstroke_out, restart_needed, contact_error, rampdown_error, error_flag;
	int         err_count = 0;
	int         n_compared = 0;
	always #4 mclk = ~mclk;
	// short tick keeps restart pulse times within a few thousand cycles
	pccm_monitor #(.TICK_CYC(4)) pccm_monitor_i (.mclk, .rst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pready, .prdata, .pslverr, .upper_position_contact(upper),
		.lower_position_contact(lower), .advance_contact(advance), .enable_in, .restart_in,
		.drive_cmd, .release_out, .top_out, .upstroke_out, .restart_needed, .contact_error,
		.rampdown_error, .error_flag, .irq);
	pccm_press_model pccm_press_model_i (.mclk, .rst_n, .go, .bad, .adv, .drive_ok,
		.upper_q(upper), .lower_q(lower), .adv_q(advance), .drive_cmd);
	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// for a read, d is the expected word
	task apb(input [7:0] a, input w, input [31:0] d, input perr);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do @(posedge mclk); while (pready !== 1'h1);
		if (!w)
			chk(prdata, d);
		chk(pslverr, perr);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge mclk);
	endtask
	task press_go;
		go <= 1'h1;
		cyc(1);
		go <= 1'h0;
		cyc(20);
	endtask
	task pulse(input int n);
		restart_in <= 1'h1;
		cyc(n);
		restart_in <= 1'h0;
		cyc(20);
	endtask
	task print_verdict;
		if (err_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task t_regs;
		apb(`PCCM_OFS_CTRL, 1'h0, 32'h0, 1'h0);
		apb(8'h14, 1'h0, 32'h0, 1'h1);
		apb(`PCCM_OFS_IRQ_EN, 1'h1, 32'h3, 1'h0);
		apb(`PCCM_OFS_IRQ_EN, 1'h0, 32'h3, 1'h0);
		apb(`PCCM_OFS_CTRL, 1'h1, 32'h13, 1'h0);
	endtask
	task t_good;
		cyc(20);
		chk(release_out, 1'h0);
		enable_in <= 1'h1;
		cyc(20);
		chk({release_out, top_out}, 2'h3);
		apb(`PCCM_OFS_STATUS, 1'h0, 32'h5503, 1'h0);
		enable_in <= 1'h0;
		cyc(20);
		chk(release_out, 1'h0);
		enable_in <= 1'h1;
		cyc(20);
		chk({release_out, top_out}, 2'h3);
		press_go();
		cyc(ST);
		chk(top_out, 1'h0);
		cyc(ST);
		chk(upstroke_out, 1'h1);
		cyc(2 * ST);
		chk({top_out, upstroke_out}, 2'h2);
		cyc(2 * ST);
		chk({contact_error, release_out}, 2'h1);
	endtask
	task t_ramp;
		apb(`PCCM_OFS_IRQ_CLR, 1'h1, 32'hF, 1'h0);
		drive_ok <= 1'h0;
		press_go();
		cyc(ST);
		chk(rampdown_error, 1'h1);
		chk({restart_needed, release_out, top_out}, 3'h4);
		chk({error_flag, irq}, 2'h3);
		apb(`PCCM_OFS_IRQ_ST, 1'h0, 32'h2, 1'h0);
		apb(`PCCM_OFS_IRQ_CLR, 1'h1, 32'h2, 1'h0);
		chk(irq, 1'h0);
		cyc(5 * ST);
		drive_ok <= 1'h1;
		pulse(200);
		chk(restart_needed, 1'h1);
		pulse(520);
		chk({restart_needed, rampdown_error, release_out}, 3'h1);
	endtask
	task t_contact;
		bad <= 1'h1;
		press_go();
		cyc(4 * ST);
		chk({contact_error, restart_needed, release_out, top_out}, 4'hC);
		enable_in <= 1'h0;
		cyc(3 * ST);
		chk(contact_error, 1'h1);
		bad <= 1'h0;
		enable_in <= 1'h1;
		apb(`PCCM_OFS_CTRL, 1'h1, 32'h0, 1'h0);
		apb(`PCCM_OFS_CTRL, 1'h1, 32'hB, 1'h0);
		cyc(20);
		chk({contact_error, release_out}, 2'h1);
	endtask
	task t_adv;
		adv <= 1'h1;
		press_go();
		cyc(3 * ST);
		chk({top_out, upstroke_out}, 2'h2);
		cyc(3 * ST);
		chk({contact_error, top_out}, 2'h1);
	endtask
	// a drive rise inside the top phase excuses a low drive at its end
	task t_seen;
		drive_ok <= 1'h0;
		cyc(10);
		drive_ok <= 1'h1;
		cyc(10);
		drive_ok <= 1'h0;
		press_go();
		cyc(ST);
		chk({rampdown_error, release_out, top_out}, 3'h2);
	endtask
	initial begin
		cyc(2);
		rst_n <= 1'h1;
		t_regs();
		t_good();
		t_ramp();
		t_contact();
		t_adv();
		t_seen();
		print_verdict();
	end
	initial begin
		#100000;
		err_count++;
		print_verdict();
	end
endmodule // testbench
bind pccm_monitor pccm_monitor_checker pccm_monitor_checker_i (.mclk, .rst_n, .psel, .enable_in,
	.restart_in, .release_out, .top_out, .upstroke_out, .restart_needed, .contact_error,
	.rampdown_error, .error_flag);
